// ---- core/ccp_capture_port.sv ----
// Parallel camera capture port: sensor-clock front end, pixel assembly, crossing to system clock
`default_nettype none
module ccp_capture_port (
  // System clock and reset
  input  wire logic                        clock,
  input  wire logic                        nrst,
  // Capture control, system domain
  input  wire logic                        captureEnable,
  input  wire logic [ccp_pkg::MODE_W-1:0]  captureMode,
  // Sensor link
  input  wire logic                        sensorPixelClock,
  input  wire logic [ccp_pkg::BUS_W-1:0]   sensorPixelBus,
  // Captured pixels, system domain
  output logic                             pixelValid,
  output logic [ccp_pkg::WORD_W-1:0]       pixelData,
  output logic                             pixelLineStart,
  // Recovered timing and status, system domain
  output logic                             recoveredFrameSync,
  output logic                             recoveredLineSync,
  output logic                             captureOverrun
);
  localparam int BW = ccp_pkg::BUS_W;
  localparam int WW = ccp_pkg::WORD_W;

  // Pixel-clock domain
  logic                  rstMeta;
  logic                  pixRstN;
  logic [4:0]            cfgS1;
  logic [4:0]            cfgS2;
  logic [4:0]            cfgS3;
  logic                  cfgEnable;
  logic [3:0]            cfgMode;
  logic                  cfgChange;
  logic                  embedded;
  logic [BW-1:0]         busSample;
  logic                  busValid;
  logic                  detValid;
  logic [BW-1:0]         detData;
  logic                  detHit;
  logic                  detField;
  logic                  detV;
  logic                  detH;
  logic                  lineActive;
  logic                  vBlank;
  logic                  hBlank;
  logic                  fieldOdd;
  logic                  take;
  logic [7:0]            sampByte;
  ccp_pkg::ccp_phase_type phase;
  ccp_pkg::ccp_phase_type lastPhase;
  logic [7:0]            holdA;
  logic [7:0]            holdB;
  logic                  next_pushValid;
  logic [WW-1:0]         next_pushData;
  logic                  pushValid;
  logic [WW-1:0]         pushData;
  logic                  pushFirst;
  logic                  linePending;
  logic                  wFull;
  logic                  overrun;
  // System-clock domain
  logic                  rValid;
  logic [WW:0]           rData;
  logic [2:0]            lvlS1;
  logic [2:0]            lvlS2;
  logic [2:0]            lvlS3;
  logic [2:0]            lvlOut;

  // Link-side reset follows the system reset through two flops
  always_ff @(posedge sensorPixelClock) begin
    rstMeta <= nrst;
    pixRstN <= rstMeta;
  end

  // Control crosses into the pixel domain; a new value counts once two stages agree
  always_ff @(posedge sensorPixelClock) begin
    if (!pixRstN) begin
      cfgS1 <= ccp_pkg::CFG_RESET;
      cfgS2 <= ccp_pkg::CFG_RESET;
      cfgS3 <= ccp_pkg::CFG_RESET;
    end else begin
      cfgS1 <= {captureEnable, captureMode};
      cfgS2 <= cfgS1;
      cfgS3 <= cfgS2;
    end
  end

  assign cfgChange = cfgS2 == cfgS3 && cfgS2 != {cfgEnable, cfgMode};

  always_ff @(posedge sensorPixelClock) begin
    if (!pixRstN) begin
      {cfgEnable, cfgMode} <= ccp_pkg::CFG_RESET;
    end else if (cfgChange) begin
      {cfgEnable, cfgMode} <= cfgS2;
    end
  end

  assign embedded = ccp_pkg::is_embedded(cfgMode);
  assign lastPhase = ccp_pkg::last_phase(cfgMode);

  // Bus sampled on the rising pixel clock edge only
  always_ff @(posedge sensorPixelClock) begin
    if (!pixRstN) begin
      busSample <= '0;
      busValid  <= 1'b0;
    end else begin
      busSample <= sensorPixelBus;
      busValid  <= cfgEnable;
    end
  end

  ccp_code_detect #(
    .DW (BW)
  ) u_detect (
    .clk        (sensorPixelClock),
    .rstN       (pixRstN),
    .detectOn   (embedded),
    .inValid    (busValid),
    .inData     (busSample),
    .outValid   (detValid),
    .outData    (detData),
    .codeHit    (detHit),
    .codeField  (detField),
    .codeVblank (detV),
    .codeHblank (detH)
  );

  // Syncs come only from codes in the data; a start code inside vertical blanking opens no line
  always_ff @(posedge sensorPixelClock) begin
    if (!pixRstN || !cfgEnable) begin
      lineActive <= 1'b0;
      vBlank     <= 1'b1;
      hBlank     <= 1'b1;
      fieldOdd   <= 1'b0;
    end else if (detHit) begin
      lineActive <= !detH && !detV;
      vBlank     <= detV;
      hBlank     <= detH;
      fieldOdd   <= detField;
    end
  end

  // Generic modes take every sample; embedded ones only inside the active line
  assign take = detValid && cfgEnable && (!embedded || lineActive);
  assign sampByte = detData[BW-1 -: 8];

  // Component order restarts at every code and on any change of setup
  always_ff @(posedge sensorPixelClock) begin
    if (!pixRstN || !cfgEnable || detHit || cfgChange) begin
      phase <= ccp_pkg::PH_FIRST;
    end else if (take) begin
      case (phase)
        ccp_pkg::PH_FIRST:  phase <= (lastPhase == ccp_pkg::PH_FIRST) ? ccp_pkg::PH_FIRST : ccp_pkg::PH_SECOND;
        ccp_pkg::PH_SECOND: phase <= (lastPhase == ccp_pkg::PH_SECOND) ? ccp_pkg::PH_FIRST : ccp_pkg::PH_THIRD;
        ccp_pkg::PH_THIRD:  phase <= ccp_pkg::PH_FIRST;
        default:            phase <= ccp_pkg::PH_FIRST;
      endcase
    end
  end

  // Partial pixel store; 5- and 6-bit components of the three-cycle modes are widened as they arrive
  always_ff @(posedge sensorPixelClock) begin
    if (!pixRstN) begin
      holdA <= 8'h00;
      holdB <= 8'h00;
    end else if (take) begin
      case (cfgMode)
        ccp_pkg::MODE_RGB565_3C: begin
          if (phase == ccp_pkg::PH_FIRST) holdA <= ccp_pkg::ext5(detData[BW-1 -: 5]);
          if (phase == ccp_pkg::PH_SECOND) holdB <= ccp_pkg::ext6(detData[BW-1 -: 6]);
        end
        ccp_pkg::MODE_RGB666_3C: begin
          if (phase == ccp_pkg::PH_FIRST) holdA <= ccp_pkg::ext6(detData[BW-1 -: 6]);
          if (phase == ccp_pkg::PH_SECOND) holdB <= ccp_pkg::ext6(detData[BW-1 -: 6]);
        end
        ccp_pkg::MODE_RGB888_3C: begin
          if (phase == ccp_pkg::PH_FIRST) holdA <= sampByte;
          if (phase == ccp_pkg::PH_SECOND) holdB <= sampByte;
        end
        ccp_pkg::MODE_RGB565_2C, ccp_pkg::MODE_YC8_EMB: begin
          if (phase == ccp_pkg::PH_FIRST) holdA <= sampByte;
        end
        default: begin
          holdA <= holdA;
        end
      endcase
    end
  end

  always_comb begin
    next_pushValid = 1'b0;
    next_pushData  = '0;
    if (take) begin
      case (cfgMode)
        ccp_pkg::MODE_RGB565_2C: begin
          next_pushValid = phase == ccp_pkg::PH_SECOND;
          next_pushData  = ccp_pkg::expand565({sampByte, holdA});
        end
        ccp_pkg::MODE_RGB565_3C: begin
          next_pushValid = phase == ccp_pkg::PH_THIRD;
          next_pushData  = {holdA, holdB, ccp_pkg::ext5(detData[BW-1 -: 5])};
        end
        ccp_pkg::MODE_RGB666_3C: begin
          next_pushValid = phase == ccp_pkg::PH_THIRD;
          next_pushData  = {holdA, holdB, ccp_pkg::ext6(detData[BW-1 -: 6])};
        end
        ccp_pkg::MODE_RGB888_3C: begin
          next_pushValid = phase == ccp_pkg::PH_THIRD;
          next_pushData  = {holdA, holdB, sampByte};
        end
        ccp_pkg::MODE_YC8_EMB: begin
          next_pushValid = phase == ccp_pkg::PH_SECOND;
          next_pushData  = {8'h00, holdA, sampByte};
        end
        ccp_pkg::MODE_RGB16_PROC: begin
          next_pushValid = 1'b1;
          next_pushData  = ccp_pkg::expand565(detData[BW-1 -: 16]);
        end
        ccp_pkg::MODE_RGB16_RAW, ccp_pkg::MODE_YC16_RAW, ccp_pkg::MODE_YC16_EMB: begin
          next_pushValid = 1'b1;
          next_pushData  = {8'h00, detData[BW-1 -: 16]};
        end
        default: begin
          next_pushValid = 1'b1;
          next_pushData  = {4'h0, detData};
        end
      endcase
    end
  end

  // First pixel after an active start code carries the line-start mark
  always_ff @(posedge sensorPixelClock) begin
    if (!pixRstN || !cfgEnable) begin
      linePending <= 1'b0;
    end else if (detHit && !detH && !detV) begin
      linePending <= 1'b1;
    end else if (next_pushValid) begin
      linePending <= 1'b0;
    end
  end

  always_ff @(posedge sensorPixelClock) begin
    if (!pixRstN) begin
      pushValid <= 1'b0;
      pushData  <= '0;
      pushFirst <= 1'b0;
    end else begin
      pushValid <= next_pushValid;
      pushData  <= next_pushData;
      pushFirst <= next_pushValid && linePending;
    end
  end

  // A word lost to a full crossing is flagged until reset
  always_ff @(posedge sensorPixelClock) begin
    if (!pixRstN) begin
      overrun <= 1'b0;
    end else if (pushValid && wFull) begin
      overrun <= 1'b1;
    end
  end

  ccp_word_cross #(
    .W  (WW + 1),
    .AW (ccp_pkg::FIFO_AW)
  ) u_cross (
    .wClk   (sensorPixelClock),
    .wRstN  (pixRstN),
    .wValid (pushValid),
    .wData  ({pushFirst, pushData}),
    .wFull  (wFull),
    .rClk   (clock),
    .rRstN  (nrst),
    .rValid (rValid),
    .rData  (rData)
  );

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pixelValid     <= 1'b0;
      pixelData      <= '0;
      pixelLineStart <= 1'b0;
    end else begin
      pixelValid     <= rValid;
      pixelData      <= rData[WW-1:0];
      pixelLineStart <= rValid && rData[WW];
    end
  end

  // Status levels enter the system domain through three flops
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lvlS1 <= 3'h3;
      lvlS2 <= 3'h3;
      lvlS3 <= 3'h3;
    end else begin
      lvlS1 <= {overrun, hBlank, vBlank};
      lvlS2 <= lvlS1;
      lvlS3 <= lvlS2;
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_lvl
    always_ff @(posedge clock) begin
      if (!nrst) begin
        lvlOut[i] <= (i < 2);
      end else if (lvlS2[i] == lvlS3[i]) begin
        lvlOut[i] <= lvlS2[i];
      end
    end
  end

  assign recoveredFrameSync = lvlOut[0];
  assign recoveredLineSync  = lvlOut[1];
  assign captureOverrun     = lvlOut[2];

  chk_blank_not_stored: assert property (@(posedge sensorPixelClock) disable iff (!pixRstN)
    (embedded && !lineActive) |-> !take)
    else $error("blanking sample taken as pixel");

  chk_sav_opens_line: assert property (@(posedge sensorPixelClock) disable iff (!pixRstN)
    (detHit && cfgEnable && !cfgChange && !detH && !detV) |=> lineActive ##1 !detValid [*2])
    else $error("start code did not open an active line");

  chk_yc8_pair: assert property (@(posedge sensorPixelClock) disable iff (!pixRstN)
    (cfgMode == ccp_pkg::MODE_YC8_EMB && take && phase == ccp_pkg::PH_SECOND)
    |=> pushValid && pushData[15:8] == $past(holdA) && pushData[7:0] == $past(sampByte))
    else $error("8-bit luma/chroma pair misassembled");

  chk_wide_per_cycle: assert property (@(posedge sensorPixelClock) disable iff (!pixRstN)
    (cfgMode == ccp_pkg::MODE_YC20_EMB && take) |=> pushValid && pushData[19:0] == $past(detData))
    else $error("wide luma/chroma sample not passed each cycle");

  chk_565_extend: assert property (@(posedge sensorPixelClock) disable iff (!pixRstN)
    (cfgMode == ccp_pkg::MODE_RGB565_3C && take && phase == ccp_pkg::PH_THIRD)
    |=> pushData[18:16] == pushData[23:21] && pushData[9:8] == pushData[15:14] && pushData[2:0] == pushData[7:5])
    else $error("5-6-5 component extension wrong");

  chk_666_extend: assert property (@(posedge sensorPixelClock) disable iff (!pixRstN)
    (cfgMode == ccp_pkg::MODE_RGB666_3C && take && phase == ccp_pkg::PH_THIRD)
    |=> pushData[17:16] == pushData[23:22] && pushData[9:8] == pushData[15:14] && pushData[1:0] == pushData[7:6])
    else $error("6-6-6 component extension wrong");

  chk_yc16_raw: assert property (@(posedge sensorPixelClock) disable iff (!pixRstN)
    (cfgMode == ccp_pkg::MODE_YC16_RAW && take) |=> pushValid && pushData == {8'h00, $past(detData[19:4])})
    else $error("raw 16-bit luma/chroma altered");

  chk_yc_needs_line: assert property (@(posedge sensorPixelClock) disable iff (!pixRstN)
    (take && (cfgMode == ccp_pkg::MODE_YC8_EMB || cfgMode == ccp_pkg::MODE_YC16_EMB
              || cfgMode == ccp_pkg::MODE_YC20_EMB)) |-> lineActive)
    else $error("luma/chroma sample taken outside an active line");

  chk_rgb16_proc: assert property (@(posedge sensorPixelClock) disable iff (!pixRstN)
    (cfgMode == ccp_pkg::MODE_RGB16_PROC && take) |=> pushData == ccp_pkg::expand565($past(detData[19:4])))
    else $error("processed 16-bit RGB misexpanded");

  chk_phase_onehot: assert property (@(posedge sensorPixelClock) disable iff (!pixRstN)
    $onehot(phase) and (take && phase == lastPhase |=> phase == ccp_pkg::PH_FIRST || detHit))
    else $error("component phase lost its order");

  cov_sav_yc8: cover property (@(posedge sensorPixelClock) disable iff (!pixRstN)
    cfgMode == ccp_pkg::MODE_YC8_EMB && detHit && !detH && !detV ##[1:20] pushValid);
  cov_rgb565_3c: cover property (@(posedge sensorPixelClock) disable iff (!pixRstN)
    cfgMode == ccp_pkg::MODE_RGB565_3C && pushValid);
  cov_eav_close: cover property (@(posedge sensorPixelClock) disable iff (!pixRstN)
    lineActive && detHit && detH);
  cov_sys_pixel: cover property (@(posedge clock) disable iff (!nrst) pixelValid && pixelLineStart);
endmodule
`default_nettype wire

// ---- shared/ccp_pkg.sv ----
// Constants, types and decode helpers for the camera parallel capture port
// Function
// - 8-bit embedded-sync mode takes one component per pixel clock cycle.
// - Wide embedded-sync mode takes luma and chroma side by side each cycle.
// - Only samples between start and end of active video codes are pixels.
// - Blanking samples between end and next start codes are never stored.
// - Timing codes are detected, stripped, and frame/line syncs regenerated.
// - Pixel clock is the only control line; no sync pins in embedded mode.
// - 5-6-5 over three cycles: extend components by copying MSBs into LSBs.
// - 6-6-6 over three cycles: copy two MSBs into two LSBs of each component.
// - 8-bit luma/chroma two-cycle input only within 8-bit embedded-sync mode.
// - 16-bit RGB one cycle: raw generic data, or processed with sync restrictions.
// - 16-bit luma/chroma captured raw, without any conversion.
// - 16-bit luma/chroma also accepted as reduced wide embedded-sync mode.
// - 20-bit luma/chroma one cycle only under wide embedded-sync mode.
`default_nettype none
package ccp_pkg;
  localparam int BUS_W = 20;
  localparam int WORD_W = 24;
  localparam int MODE_W = 4;
  localparam int KEY_W = 8;
  localparam int FIFO_AW = 2;
  localparam logic [3:0] MODE_RGB565_2C = 4'h0;
  localparam logic [3:0] MODE_RGB565_3C = 4'h1;
  localparam logic [3:0] MODE_RGB666_3C = 4'h2;
  localparam logic [3:0] MODE_RGB888_3C = 4'h3;
  localparam logic [3:0] MODE_YC8_EMB = 4'h4;
  localparam logic [3:0] MODE_RGB16_RAW = 4'h5;
  localparam logic [3:0] MODE_RGB16_PROC = 4'h6;
  localparam logic [3:0] MODE_YC16_RAW = 4'h7;
  localparam logic [3:0] MODE_YC16_EMB = 4'h8;
  localparam logic [3:0] MODE_YC20_EMB = 4'h9;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam logic [7:0] CODE_ONES = 8'hFF;
  localparam logic [7:0] CODE_ZERO = 8'h00;
  localparam int CODE_MARK_BIT = 7;
  localparam int CODE_F_BIT = 6;
  localparam int CODE_V_BIT = 5;
  localparam int CODE_H_BIT = 4;
  localparam logic [1:0] CODE_KILL = 2'h3;

  typedef enum logic [2:0] {
    PH_FIRST  = 3'h1,
    PH_SECOND = 3'h2,
    PH_THIRD  = 3'h4
  } ccp_phase_type;

  function automatic logic is_embedded(input logic [3:0] mode);
    return mode == MODE_YC8_EMB || mode == MODE_RGB16_PROC || mode == MODE_YC16_EMB || mode == MODE_YC20_EMB;
  endfunction

  function automatic ccp_phase_type last_phase(input logic [3:0] mode);
    case (mode)
      MODE_RGB565_2C, MODE_YC8_EMB: return PH_SECOND;
      MODE_RGB565_3C, MODE_RGB666_3C, MODE_RGB888_3C: return PH_THIRD;
      default: return PH_FIRST;
    endcase
  endfunction

  function automatic logic [7:0] ext5(input logic [4:0] c);
    return {c, c[4:2]};
  endfunction

  function automatic logic [7:0] ext6(input logic [5:0] c);
    return {c, c[5:4]};
  endfunction

  function automatic logic [23:0] expand565(input logic [15:0] w);
    return {ext5(w[15:11]), ext6(w[10:5]), ext5(w[4:0])};
  endfunction
endpackage
`default_nettype wire

// ---- core/ccp_code_detect.sv ----
// Embedded timing-code detector and stripper on the pixel clock
`default_nettype none
module ccp_code_detect #(
  parameter int DW = 20
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstN,
  // Sample stream in
  input  wire logic          detectOn,
  input  wire logic          inValid,
  input  wire logic [DW-1:0] inData,
  // Stream out, codes removed
  output logic               outValid,
  output logic [DW-1:0]      outData,
  output logic               codeHit,
  output logic               codeField,
  output logic               codeVblank,
  output logic               codeHblank
);
  logic [DW-1:0] hist [3];
  logic [2:0]    histValid;
  logic [1:0]    kill;
  logic [7:0]    inKey;
  logic          hit;

  assign inKey = inData[DW-1 -: ccp_pkg::KEY_W];
  assign hit = detectOn && inValid && (&histValid) && inKey[ccp_pkg::CODE_MARK_BIT]
               && hist[2][DW-1 -: ccp_pkg::KEY_W] == ccp_pkg::CODE_ONES
               && hist[1][DW-1 -: ccp_pkg::KEY_W] == ccp_pkg::CODE_ZERO
               && hist[0][DW-1 -: ccp_pkg::KEY_W] == ccp_pkg::CODE_ZERO;

  // Three-sample delay so the preamble can be withdrawn once the code word shows up
  always_ff @(posedge clk) begin
    if (!rstN) begin
      histValid <= 3'h0;
      for (int i = 0; i < 3; i++) hist[i] <= '0;
    end else begin
      histValid <= {histValid[1:0], inValid};
      hist[0] <= inData;
      for (int i = 1; i < 3; i++) hist[i] <= hist[i-1];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstN) begin
      outValid <= 1'b0;
      outData  <= '0;
      kill     <= 2'h0;
    end else begin
      outValid <= histValid[2] && !hit && kill == 2'h0;
      outData  <= hist[2];
      kill     <= hit ? ccp_pkg::CODE_KILL : (kill != 2'h0 ? kill - 2'h1 : 2'h0);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstN) begin
      codeHit    <= 1'b0;
      codeField  <= 1'b0;
      codeVblank <= 1'b1;
      codeHblank <= 1'b1;
    end else begin
      codeHit <= hit;
      if (hit) begin
        codeField  <= inKey[ccp_pkg::CODE_F_BIT];
        codeVblank <= inKey[ccp_pkg::CODE_V_BIT];
        codeHblank <= inKey[ccp_pkg::CODE_H_BIT];
      end
    end
  end

  chk_code_strip: assert property (@(posedge clk) disable iff (!rstN)
    codeHit |-> !outValid ##1 !outValid [*3])
    else $error("timing code leaked into the sample stream");
endmodule
`default_nettype wire

// ---- core/ccp_word_cross.sv ----
// Gray-pointer word crossing from the pixel clock to the system clock
`default_nettype none
module ccp_word_cross #(
  parameter int W  = 25,
  parameter int AW = 2
) (
  // Write side
  input  wire logic         wClk,
  input  wire logic         wRstN,
  input  wire logic         wValid,
  input  wire logic [W-1:0] wData,
  output logic              wFull,
  // Read side, always draining
  input  wire logic         rClk,
  input  wire logic         rRstN,
  output logic              rValid,
  output logic [W-1:0]      rData
);
  logic [W-1:0] mem [2**AW];
  logic [AW:0]  wPtr, wGray, rPtr, rGray;
  logic [AW:0]  rGrayS1, rGrayS2, wGrayS1, wGrayS2;
  logic [AW:0]  wPtrNext, rPtrNext;
  logic         empty;

  assign wPtrNext = wPtr + 1'b1;
  assign rPtrNext = rPtr + 1'b1;
  assign wFull = wGray == {~rGrayS2[AW:AW-1], rGrayS2[AW-2:0]};
  assign empty = rGray == wGrayS2;

  always_ff @(posedge wClk) begin
    if (!wRstN) begin
      wPtr  <= '0;
      wGray <= '0;
    end else if (wValid && !wFull) begin
      mem[wPtr[AW-1:0]] <= wData;
      wPtr  <= wPtrNext;
      wGray <= wPtrNext ^ (wPtrNext >> 1);
    end
  end

  always_ff @(posedge wClk) begin
    if (!wRstN) begin
      rGrayS1 <= '0;
      rGrayS2 <= '0;
    end else begin
      rGrayS1 <= rGray;
      rGrayS2 <= rGrayS1;
    end
  end

  always_ff @(posedge rClk) begin
    if (!rRstN) begin
      wGrayS1 <= '0;
      wGrayS2 <= '0;
    end else begin
      wGrayS1 <= wGray;
      wGrayS2 <= wGrayS1;
    end
  end

  always_ff @(posedge rClk) begin
    if (!rRstN) begin
      rPtr   <= '0;
      rGray  <= '0;
      rValid <= 1'b0;
      rData  <= '0;
    end else begin
      rValid <= !empty;
      if (!empty) begin
        rData <= mem[rPtr[AW-1:0]];
        rPtr  <= rPtrNext;
        rGray <= rPtrNext ^ (rPtrNext >> 1);
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/ccp_sensor_model.sv ----
// Image sensor model driving the parallel pixel bus
`default_nettype none
module ccp_sensor_model (
  // Link
  input  wire logic                      sensorPixelClock,
  output logic [ccp_pkg::BUS_W-1:0]      sensorPixelBus
);
  timeunit 1ns;
  timeprecision 100ps;
  initial sensorPixelBus = 20'h80000;
  // Bus changes just after the sampling edge; one sample per pixel clock
  task automatic put(input logic [ccp_pkg::BUS_W-1:0] v);
    @(posedge sensorPixelClock);
    #2 sensorPixelBus = v;
  endtask
  // Pixel clock is the only control line; timing travels in the data
  task automatic code(input logic [7:0] xy);
    put(20'hFF000);
    put(20'h00000);
    put(20'h00000);
    put({xy, 12'h000});
  endtask
  // Changing blanking filler so a stale value is never mistaken for data
  task automatic blank(input int n);
    repeat (n) begin
      put(20'h80000);
      put(20'h10000);
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the camera capture port
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        pclk = 1'b0;
  logic        captureEnable = 1'b0;
  logic [3:0]  captureMode = 4'h0;
  logic [19:0] bus;
  logic        pixelValid, pixelLineStart, frameSync, lineSync, overrun;
  logic [23:0] pixelData;
  logic [24:0] seen[$];
  logic [19:0] px[$];
  logic [19:0] fill;
  int          gap = 3;
  int          errors = 0;
  int          total_checks = 0;
  `define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value %s expected %h seen %h", what, exp, got); end end
  always #12.5 clock = ~clock;
  always #16 pclk = ~pclk;
  ccp_sensor_model u_ccp_sensor_model (.sensorPixelClock(pclk), .sensorPixelBus(bus));
  ccp_capture_port u_ccp_capture_port (
    .clock(clock), .nrst(nrst), .captureEnable(captureEnable), .captureMode(captureMode),
    .sensorPixelClock(pclk), .sensorPixelBus(bus), .pixelValid(pixelValid), .pixelData(pixelData),
    .pixelLineStart(pixelLineStart), .recoveredFrameSync(frameSync), .recoveredLineSync(lineSync),
    .captureOverrun(overrun)
  );
  // Pulses are taken mid-cycle, well clear of the edge that launches them
  always @(negedge clock) begin
    if (pixelValid === 1'b1) begin
      seen.push_back({pixelLineStart, pixelData});
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic setup(input logic [3:0] mode);
    @(posedge clock);
    #3 captureMode = mode;
    captureEnable = 1'b1;
    repeat (12) @(posedge pclk);
    seen.delete();
  endtask
  // Bounded wait for words, then extra time so stray blanking words would show up
  task automatic wait_words(input int n);
    int k;
    for (k = 0; k < 200 && seen.size() < n; k++) @(posedge clock);
    if (seen.size() < n) begin
      errors++;
      tally_and_finish();
    end
    repeat (40) @(posedge clock);
  endtask
  // One embedded line: lead code, the samples in px, closing code, then blanking
  task automatic send_line(input logic [7:0] lead, input logic [7:0] tail);
    u_ccp_sensor_model.code(lead);
    foreach (px[i]) u_ccp_sensor_model.put(px[i]);
    u_ccp_sensor_model.code(tail);
    u_ccp_sensor_model.blank(gap);
  endtask
  // Two bytes per word between start and end codes, blanking dropped
  task automatic test_yc8();
    setup(ccp_pkg::MODE_YC8_EMB);
    u_ccp_sensor_model.blank(gap);
    px = '{20'h11000, 20'h22000, 20'h33000, 20'h44000};
    send_line(8'h80, 8'h90);
    wait_words(2);
    `CHK("yc8 count", 2, seen.size())
    `CHK("yc8 word0", 25'h1001122, seen[0])
    `CHK("yc8 word1", 25'h0003344, seen[1])
    `CHK("line sync", 1'b1, lineSync)
    `CHK("frame sync", 1'b0, frameSync)
    `CHK("overrun", 1'b0, overrun)
    $display("yc8 test done");
  endtask
  // Luma and chroma side by side, one word per pixel clock
  task automatic test_yc20();
    setup(ccp_pkg::MODE_YC20_EMB);
    px = '{20'h55555};
    send_line(8'hA0, 8'hB0);
    `CHK("frame sync vblank", 1'b1, frameSync)
    px = '{20'hABCDE, 20'h12345};
    send_line(8'h80, 8'h90);
    wait_words(2);
    `CHK("yc20 count", 2, seen.size())
    `CHK("yc20 word0", 25'h10ABCDE, seen[0])
    `CHK("yc20 word1", 25'h0012345, seen[1])
    $display("yc20 test done");
  endtask
  // Processed 16-bit RGB inside an embedded line comes out widened to 8-8-8
  task automatic test_rgb16();
    setup(ccp_pkg::MODE_RGB16_PROC);
    px = '{20'h8A510};
    send_line(8'h80, 8'h90);
    wait_words(1);
    `CHK("rgb16 count", 1, seen.size())
    `CHK("rgb16 word0", 25'h18C498C, seen[0])
    $display("rgb16 test done");
  endtask
  // Generic three-cycle packings; a steady sample makes every word independent of phase
  task automatic test_rgb3c();
    fill = 20'hB4000;
    u_ccp_sensor_model.put(fill);
    setup(ccp_pkg::MODE_RGB565_3C);
    wait_words(2);
    `CHK("565 word", 25'h0B5B6B5, seen[0])
    setup(ccp_pkg::MODE_RGB666_3C);
    wait_words(2);
    `CHK("666 word0", 25'h0B6B6B6, seen[0])
    `CHK("666 word last", 25'h0B6B6B6, seen[seen.size()-1])
    `CHK("generic overrun", 1'b0, overrun)
    $display("rgb3c test done");
  endtask
  initial begin
    repeat (16) @(posedge clock);
    #3 nrst = 1'b1;
    test_yc8();
    test_yc20();
    test_rgb16();
    test_rgb3c();
    tally_and_finish();
  end
endmodule
`default_nettype wire
